/* hdl/spbm_pkg.sv */
// Constants for the self-programming boot map and control register.
package spbm_pkg;
  // ----------------------------------------
  // Register addressing
  // ----------------------------------------
  localparam logic [7:0] CSR_DATA_OFFSET = 8'h57;
  localparam logic [7:0] IO_SPACE_BASE = 8'h20;
  localparam logic [7:0] CSR_IO_ADDR = CSR_DATA_OFFSET - IO_SPACE_BASE;
  localparam logic [7:0] CSR_RESET = 8'h00;
  // ----------------------------------------
  // Control and status field positions
  // ----------------------------------------
  localparam int BIT_READY_IRQ_ENABLE = 7;
  localparam int BIT_REGION_BUSY = 6;
  localparam int BIT_SIGNATURE_READ = 5;
  localparam int BIT_REGION_READ_ENABLE = 4;
  localparam int BIT_LOCK_BIT_SET = 3;
  localparam int BIT_PAGE_WRITE = 2;
  localparam int BIT_PAGE_ERASE = 1;
  localparam int BIT_STORE_ENABLE = 0;
  // ----------------------------------------
  // Timing windows in core cycles
  // ----------------------------------------
  localparam logic [2:0] STORE_WINDOW_CYCLES = 3'h4;
  localparam logic [2:0] LOAD_WINDOW_CYCLES = 3'h3;
  // ----------------------------------------
  // Address maps, 4K-word and 8K-word
  // ----------------------------------------
  localparam logic [12:0] HALT_START_4K = 13'h0C00;
  localparam logic [12:0] HALT_START_8K = 13'h1C00;
  localparam logic [12:0] BOOT_START_4K_3 = 13'h0F80;
  localparam logic [12:0] BOOT_START_4K_2 = 13'h0F00;
  localparam logic [12:0] BOOT_START_4K_1 = 13'h0E00;
  localparam logic [12:0] BOOT_START_4K_0 = 13'h0C00;
  localparam logic [12:0] BOOT_START_8K_3 = 13'h1F80;
  localparam logic [12:0] BOOT_START_8K_2 = 13'h1F00;
  localparam logic [12:0] BOOT_START_8K_1 = 13'h1E00;
  localparam logic [12:0] BOOT_START_8K_0 = 13'h1C00;
  localparam int PAGE_LSB_4K = 6;
  localparam int PAGE_LSB_8K = 7;
  // ----------------------------------------
  // Sequencer states
  // ----------------------------------------
  typedef enum logic [2:0] {
    SPBM_IDLE = 3'b001,
    SPBM_ARMED = 3'b010,
    SPBM_BUSY = 3'b100
  } spbm_state_t;
endpackage

/* hdl/spbm_top.sv */
// Self-programming boot map, pointer decode and control register.
`timescale 1ns/10ps
`default_nettype none
module spbm_top #(
  parameter bit WORDS_8K = 1'b0
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [1:0] boot_size_field,
  input wire logic global_irq_enable,
  input wire logic [7:0] bus_addr,
  input wire logic bus_io_space,
  input wire logic bus_wr,
  input wire logic bus_rd,
  input wire logic [7:0] bus_wdata,
  input wire logic spm_exec,
  input wire logic lpm_exec,
  input wire logic [15:0] z_ptr,
  input wire logic flash_done,
  output logic [7:0] bus_rdata,
  output logic ready_irq,
  output logic [12:0] boot_start,
  output logic [12:0] app_end,
  output logic [6:0] page_select,
  output logic [5:0] buffer_word_select,
  output logic byte_select,
  output logic page_in_concurrent,
  output logic page_erase_go,
  output logic page_write_go,
  output logic buffer_fill_go,
  output logic lock_set_go,
  output logic lock_read_go,
  output logic signature_read_go,
  output logic region_reenable_go
);
  // ----------------------------------------
  // Reset release and fuse synchroniser
  // ----------------------------------------
  logic rst_meta_q;
  logic rst_n_q;
  logic [1:0] fuse_meta_q;
  logic [1:0] fuse_q;
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rst_meta_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q <= rst_meta_q;
    end
  end
  always_ff @(posedge core_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      fuse_meta_q <= 2'h0;
      fuse_q <= 2'h0;
    end else begin
      fuse_meta_q <= boot_size_field;
      fuse_q <= fuse_meta_q;
    end
  end

  // ----------------------------------------
  // Address map decode
  // ----------------------------------------
  logic [12:0] boot_start_d;
  logic [12:0] boot_start_q;
  logic [12:0] app_end_q;
  logic [6:0] page_d;
  logic [6:0] page_q;
  logic [5:0] word_d;
  logic [5:0] word_q;
  logic byte_q;
  logic in_region_d;
  logic in_region_q;
  logic [12:0] page_base;
  always_comb begin
    if (WORDS_8K) begin
      case (fuse_q)
        2'h3: boot_start_d = spbm_pkg::BOOT_START_8K_3;
        2'h2: boot_start_d = spbm_pkg::BOOT_START_8K_2;
        2'h1: boot_start_d = spbm_pkg::BOOT_START_8K_1;
        default: boot_start_d = spbm_pkg::BOOT_START_8K_0;
      endcase
      page_d = z_ptr[13:spbm_pkg::PAGE_LSB_8K];
      word_d = z_ptr[6:1];
      page_base = {page_d, 6'h00};
      in_region_d = page_base < spbm_pkg::HALT_START_8K;
    end else begin
      case (fuse_q)
        2'h3: boot_start_d = spbm_pkg::BOOT_START_4K_3;
        2'h2: boot_start_d = spbm_pkg::BOOT_START_4K_2;
        2'h1: boot_start_d = spbm_pkg::BOOT_START_4K_1;
        default: boot_start_d = spbm_pkg::BOOT_START_4K_0;
      endcase
      page_d = z_ptr[12:spbm_pkg::PAGE_LSB_4K];
      word_d = {1'b0, z_ptr[5:1]};
      page_base = {1'b0, page_d, 5'h00};
      in_region_d = page_base < spbm_pkg::HALT_START_4K;
    end
  end
  always_ff @(posedge core_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      boot_start_q <= 13'h0000;
      app_end_q <= 13'h0000;
      page_q <= 7'h00;
      word_q <= 6'h00;
      byte_q <= 1'b0;
      in_region_q <= 1'b0;
    end else begin
      boot_start_q <= boot_start_d;
      app_end_q <= boot_start_d - 13'h0001;
      page_q <= page_d;
      word_q <= word_d;
      // Z0 is only a load byte select
      byte_q <= z_ptr[0];
      in_region_q <= in_region_d;
    end
  end

  // ----------------------------------------
  // Control register and sequencer
  // ----------------------------------------
  spbm_pkg::spbm_state_t state_d;
  spbm_pkg::spbm_state_t state_q;
  logic [7:0] csr_d;
  logic [7:0] csr_q;
  logic [2:0] win_d;
  logic [2:0] win_q;
  logic [7:0] rdata_d;
  logic [7:0] rdata_q;
  logic irq_d;
  logic irq_q;
  logic [6:0] go_d;
  logic [6:0] go_q;
  logic hit;
  logic cmd_ok;
  logic [5:0] cmd;
  always_comb begin
    state_d = state_q;
    csr_d = csr_q;
    win_d = win_q;
    go_d = 7'h00;
    rdata_d = rdata_q;
    cmd = bus_wdata[5:0];
    hit = bus_io_space ? (bus_addr == spbm_pkg::CSR_IO_ADDR)
                       : (bus_addr == spbm_pkg::CSR_DATA_OFFSET);
    // At most one command bit alongside store enable is meaningful.
    cmd_ok = cmd[spbm_pkg::BIT_STORE_ENABLE] &&
             ((cmd[5:1] & (cmd[5:1] - 5'h01)) == 5'h00);
    case (state_q)
      spbm_pkg::SPBM_IDLE: begin
        if (bus_wr && hit) begin
          csr_d[spbm_pkg::BIT_READY_IRQ_ENABLE] =
            bus_wdata[spbm_pkg::BIT_READY_IRQ_ENABLE];
          if (cmd_ok) begin
            csr_d[5:0] = cmd;
            win_d = 3'h0;
            state_d = spbm_pkg::SPBM_ARMED;
          end
        end
      end
      spbm_pkg::SPBM_ARMED: begin
        win_d = win_q + 3'h1;
        if (bus_wr && hit) begin
          csr_d[spbm_pkg::BIT_READY_IRQ_ENABLE] =
            bus_wdata[spbm_pkg::BIT_READY_IRQ_ENABLE];
        end
        if (lpm_exec && win_q < spbm_pkg::LOAD_WINDOW_CYCLES &&
            (csr_q[spbm_pkg::BIT_SIGNATURE_READ] ||
             csr_q[spbm_pkg::BIT_LOCK_BIT_SET])) begin
          go_d[5] = csr_q[spbm_pkg::BIT_LOCK_BIT_SET];
          go_d[4] = csr_q[spbm_pkg::BIT_SIGNATURE_READ];
          csr_d[5:0] = 6'h00;
          state_d = spbm_pkg::SPBM_IDLE;
        end else if (spm_exec && !csr_q[spbm_pkg::BIT_SIGNATURE_READ]) begin
          // erase and write use the latched page
          if (csr_q[spbm_pkg::BIT_PAGE_ERASE] ||
              csr_q[spbm_pkg::BIT_PAGE_WRITE]) begin
            go_d[0] = csr_q[spbm_pkg::BIT_PAGE_ERASE];
            go_d[1] = csr_q[spbm_pkg::BIT_PAGE_WRITE];
            // busy set on a concurrent-region target
            if (in_region_d) begin
              csr_d[spbm_pkg::BIT_REGION_BUSY] = 1'b1;
            end
            state_d = spbm_pkg::SPBM_BUSY;
          end else begin
            if (csr_q[spbm_pkg::BIT_REGION_READ_ENABLE]) begin
              csr_d[spbm_pkg::BIT_REGION_BUSY] = 1'b0;
              go_d[3] = 1'b1;
            end else if (csr_q[spbm_pkg::BIT_LOCK_BIT_SET]) begin
              go_d[6] = 1'b1;
            end else begin
              csr_d[spbm_pkg::BIT_REGION_BUSY] = 1'b0;
              go_d[2] = 1'b1;
            end
            csr_d[5:0] = 6'h00;
            state_d = spbm_pkg::SPBM_IDLE;
          end
        end else if (win_q == spbm_pkg::STORE_WINDOW_CYCLES - 3'h1) begin
          csr_d[5:0] = 6'h00;
          state_d = spbm_pkg::SPBM_IDLE;
        end
      end
      spbm_pkg::SPBM_BUSY: begin
        if (bus_wr && hit) begin
          csr_d[spbm_pkg::BIT_READY_IRQ_ENABLE] =
            bus_wdata[spbm_pkg::BIT_READY_IRQ_ENABLE];
        end
        // store enable holds until erase or write ends
        if (flash_done) begin
          csr_d[5:0] = 6'h00;
          state_d = spbm_pkg::SPBM_IDLE;
        end
      end
      default: begin
        csr_d = spbm_pkg::CSR_RESET;
        state_d = spbm_pkg::SPBM_IDLE;
      end
    endcase
    // bit order is the layout of csr_q
    if (bus_rd) begin
      rdata_d = hit ? csr_q : 8'h00;
    end
    // level request while store enable is low
    irq_d = csr_q[spbm_pkg::BIT_READY_IRQ_ENABLE] && global_irq_enable &&
            !csr_q[spbm_pkg::BIT_STORE_ENABLE];
  end
  always_ff @(posedge core_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      state_q <= spbm_pkg::SPBM_IDLE;
      csr_q <= spbm_pkg::CSR_RESET;
      win_q <= 3'h0;
      rdata_q <= 8'h00;
      irq_q <= 1'b0;
      go_q <= 7'h00;
    end else begin
      state_q <= state_d;
      csr_q <= csr_d;
      win_q <= win_d;
      rdata_q <= rdata_d;
      irq_q <= irq_d;
      go_q <= go_d;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // Page and word outputs track the pointer one cycle late, so strobes
  // and the address they belong to leave together.
  assign bus_rdata = rdata_q;
  assign ready_irq = irq_q;
  assign boot_start = boot_start_q;
  assign app_end = app_end_q;
  assign page_select = page_q;
  // word select passes through untouched on page write
  assign buffer_word_select = word_q;
  assign byte_select = byte_q;
  assign page_in_concurrent = in_region_q;
  assign page_erase_go = go_q[0];
  assign page_write_go = go_q[1];
  assign buffer_fill_go = go_q[2];
  assign region_reenable_go = go_q[3];
  assign signature_read_go = go_q[4];
  assign lock_read_go = go_q[5];
  assign lock_set_go = go_q[6];
endmodule
`default_nettype wire

/* dv/spbm_props.sv */
// Checker for boot map, pointer decode and register reads.
`timescale 1ns/10ps
`default_nettype none
module spbm_props #(
  parameter bit WORDS_8K = 1'b0
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic global_irq_enable,
  input wire logic [7:0] bus_addr,
  input wire logic bus_io_space,
  input wire logic bus_rd,
  input wire logic [15:0] z_ptr,
  input wire logic [7:0] bus_rdata,
  input wire logic ready_irq,
  input wire logic [12:0] boot_start,
  input wire logic [12:0] app_end,
  input wire logic [6:0] page_select,
  input wire logic [5:0] buffer_word_select,
  input wire logic byte_select,
  input wire logic page_in_concurrent
);
  localparam logic [12:0] TOP = WORDS_8K ? 13'h1FFF : 13'h0FFF;
  localparam logic [6:0] LIM = WORDS_8K ? 7'h70 : 7'h60;
  logic [2:0] up_q;
  logic [2:0] up_d;
  wire logic hit = bus_addr == (bus_io_space ? spbm_pkg::CSR_IO_ADDR :
    spbm_pkg::CSR_DATA_OFFSET);
  // Outputs settle only after reset and fuse sync, so checks wait.
  always_comb up_d = up_q + {2'h0, ~&up_q};
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) up_q <= 3'h0;
    else up_q <= up_d;
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst || up_q != 3'h7);
  sequence rd_miss;
    bus_rd && !hit ##1 !bus_rd;
  endsequence
  chk_boot_table: assert property (
    (TOP - boot_start) inside {13'h007F, 13'h00FF, 13'h01FF, 13'h03FF})
    else $error("boot start off table");
  chk_app_below: assert property (
    app_end == boot_start - 13'h0001) else $error("app end wrong");
  chk_page_field: assert property (
    page_select == $past(WORDS_8K ? z_ptr[13:7] : z_ptr[12:6]))
    else $error("page select wrong");
  chk_word_field: assert property (
    buffer_word_select == $past(WORDS_8K ? z_ptr[6:1] : {1'b0, z_ptr[5:1]}))
    else $error("word select wrong");
  chk_byte_pick: assert property (
    byte_select == $past(z_ptr[0])) else $error("byte select wrong");
  chk_region_split: assert property (
    $stable(page_select)[*2] |-> page_in_concurrent == (page_select < LIM))
    else $error("region flag wrong");
  chk_rd_unmapped: assert property (
    rd_miss |=> bus_rdata == 8'h00) else $error("unmapped read not zero");
  chk_irq_gated: assert property (
    !global_irq_enable [*3] |-> !ready_irq) else $error("irq not gated");
endmodule
bind spbm_top spbm_props #(.WORDS_8K(WORDS_8K)) u_props (
  .core_clk(core_clk), .nrst(nrst), .global_irq_enable(global_irq_enable),
  .bus_addr(bus_addr), .bus_io_space(bus_io_space), .bus_rd(bus_rd),
  .z_ptr(z_ptr), .bus_rdata(bus_rdata), .ready_irq(ready_irq),
  .boot_start(boot_start), .app_end(app_end), .page_select(page_select),
  .buffer_word_select(buffer_word_select), .byte_select(byte_select),
  .page_in_concurrent(page_in_concurrent)
);
`default_nettype wire

/* dv/spbm_core_model.sv */
// Processor core model: register accesses and store or load pulses.
`timescale 1ns/10ps
`default_nettype none
module spbm_core_model (
  input wire logic core_clk,
  input wire logic [7:0] bus_rdata,
  output logic [7:0] bus_addr,
  output logic bus_io_space,
  output logic bus_wr,
  output logic bus_rd,
  output logic [7:0] bus_wdata,
  output logic spm_exec,
  output logic lpm_exec,
  output logic [15:0] z_ptr
);
  initial {bus_addr, bus_io_space, bus_wr, bus_rd, bus_wdata} = '0;
  initial {spm_exec, lpm_exec, z_ptr} = '0;
  // Released address and data lines show inverted values so stale data never looks valid.
  task automatic wr(input logic [7:0] a, input logic io, input logic [7:0] d);
    @(negedge core_clk);
    {bus_addr, bus_io_space, bus_wdata, bus_wr} = {a, io, d, 1'b1};
    @(negedge core_clk);
    {bus_addr, bus_wdata, bus_wr} = {~a, ~d, 1'b0};
  endtask
  task automatic rd(input logic [7:0] a, input logic io, output logic [7:0] q);
    @(negedge core_clk);
    {bus_addr, bus_io_space, bus_rd} = {a, io, 1'b1};
    @(negedge core_clk);
    {bus_addr, bus_rd} = {~a, 1'b0};
    @(negedge core_clk);
    q = bus_rdata;
  endtask
  task automatic ex(input logic s, input logic [15:0] z);
    @(negedge core_clk);
    z_ptr = s ? {z[15:1], 1'b0} : z;
    {spm_exec, lpm_exec} = {s, ~s};
    @(negedge core_clk);
    {spm_exec, lpm_exec} = 2'b00;
  endtask
endmodule
`default_nettype wire

/* dv/tb.sv */
// Self-checking bench for the self-programming boot map.
`timescale 1ns/10ps
`default_nettype none
module tb;
  localparam bit W8 = 1'b0;
  localparam logic [15:0] TOP = W8 ? 16'h2000 : 16'h1000;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic [1:0] boot_size_field = 2'h3;
  logic global_irq_enable = 1'b0;
  logic flash_done = 1'b0;
  logic [7:0] bus_addr, bus_wdata, bus_rdata, q;
  logic bus_io_space, bus_wr, bus_rd, spm_exec, lpm_exec, ready_irq;
  logic byte_select, page_in_concurrent, lock_set_go, lock_read_go;
  logic page_erase_go, page_write_go, buffer_fill_go, signature_read_go;
  logic region_reenable_go;
  logic [15:0] z_ptr, z, bs;
  logic [15:0] zl [4] = '{16'hE0A3, 16'h17FF, 16'h1800, 16'h3800};
  logic [12:0] boot_start_8k, app_end_8k;
  logic [6:0] page_select_8k;
  logic [5:0] word_select_8k;
  logic byte_select_8k, in_concurrent_8k;
  logic [12:0] boot_start, app_end;
  logic [6:0] page_select, pg;
  logic [5:0] buffer_word_select;
  int failures = 0;
  int n_tests = 0;
  int cycles = 0;
  always #20 core_clk = ~core_clk;
  spbm_top #(.WORDS_8K(W8)) DUT (.*);
  // The 8K-word map runs beside the main instance on the same stimulus.
  spbm_top #(.WORDS_8K(1'b1)) DUT_8K (
    .core_clk(core_clk), .nrst(nrst), .boot_size_field(boot_size_field),
    .global_irq_enable(global_irq_enable), .bus_addr(bus_addr),
    .bus_io_space(bus_io_space), .bus_wr(bus_wr), .bus_rd(bus_rd),
    .bus_wdata(bus_wdata), .spm_exec(spm_exec), .lpm_exec(lpm_exec),
    .z_ptr(z_ptr), .flash_done(flash_done), .bus_rdata(), .ready_irq(),
    .boot_start(boot_start_8k), .app_end(app_end_8k),
    .page_select(page_select_8k), .buffer_word_select(word_select_8k),
    .byte_select(byte_select_8k), .page_in_concurrent(in_concurrent_8k),
    .page_erase_go(), .page_write_go(), .buffer_fill_go(),
    .lock_set_go(), .lock_read_go(), .signature_read_go(),
    .region_reenable_go()
  );
  spbm_core_model CORE (.*);
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run;
    if (failures == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic run_cmd(input logic [7:0] cmd, input logic s, input int dly,
    input logic [15:0] zp, input logic [6:0] go, input logic [7:0] mid,
    input logic [7:0] fin);
    CORE.wr(8'h57, 1'b0, cmd);
    repeat (dly) @(negedge core_clk);
    CORE.ex(s, zp);
    chk({page_erase_go, page_write_go, buffer_fill_go, lock_set_go,
      lock_read_go, signature_read_go, region_reenable_go}, go);
    if (mid != 8'h00) begin
      CORE.rd(8'h57, 1'b0, q);
      chk(q, mid);
      @(negedge core_clk) flash_done = 1'b1;
      @(negedge core_clk) flash_done = 1'b0;
    end
    repeat (6) @(negedge core_clk);
    CORE.rd(8'h57, 1'b0, q);
    chk(q, fin);
  endtask
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      complete_run();
    end
  end
  initial begin
    repeat (16) @(negedge core_clk);
    nrst = 1'b1;
    repeat (4) @(negedge core_clk);
    CORE.rd(8'h57, 1'b0, q);
    chk(q, 8'h00);
    for (int c = 0; c < 4; c++) begin
      boot_size_field = c[1:0];
      repeat (6) @(negedge core_clk);
      bs = TOP - (16'h0080 << (3 - c));
      chk(boot_start, bs);
      chk(app_end, bs - 16'h0001);
      chk(boot_start_8k, 16'h2000 - (16'h0080 << (3 - c)));
      chk(app_end_8k, 16'h1FFF - (16'h0080 << (3 - c)));
    end
    for (int i = 0; i < 4; i++) begin
      CORE.ex(1'b0, zl[i]);
      @(negedge core_clk);
      z = zl[i];
      pg = W8 ? z[13:7] : z[12:6];
      chk(page_select, pg);
      chk(buffer_word_select, W8 ? z[6:1] : {1'b0, z[5:1]});
      chk(byte_select, z[0]);
      chk(page_in_concurrent, pg < (W8 ? 7'h70 : 7'h60));
      chk(page_select_8k, z[13:7]);
      chk(word_select_8k, z[6:1]);
      chk(byte_select_8k, z[0]);
      chk(in_concurrent_8k, z[13:7] < 7'h70);
    end
    global_irq_enable = 1'b1;
    CORE.wr(8'h37, 1'b1, 8'h80);
    repeat (3) @(negedge core_clk);
    chk(ready_irq, 1'b1);
    CORE.rd(8'h57, 1'b0, q);
    chk(q, 8'h80);
    CORE.rd(8'h37, 1'b0, q);
    chk(q, 8'h00);
    global_irq_enable = 1'b0;
    repeat (3) @(negedge core_clk);
    chk(ready_irq, 1'b0);
    global_irq_enable = 1'b1;
    CORE.wr(8'h57, 1'b0, 8'h81);
    repeat (2) @(negedge core_clk);
    chk(ready_irq, 1'b0);
    repeat (6) @(negedge core_clk);
    chk(ready_irq, 1'b1);
    // page write with word field zero
    run_cmd(8'h05, 1'b1, 0, 16'h0040, 7'h20, 8'h45, 8'h40);
    run_cmd(8'h11, 1'b1, 0, 16'h0000, 7'h01, 8'h00, 8'h00);
    run_cmd(8'h03, 1'b1, 0, 16'h1800, 7'h40, 8'h03, 8'h00);
    run_cmd(8'h09, 1'b1, 0, 16'h0000, 7'h08, 8'h00, 8'h00);
    run_cmd(8'h01, 1'b1, 0, 16'h0002, 7'h10, 8'h00, 8'h00);
    run_cmd(8'h09, 1'b0, 0, 16'h0001, 7'h04, 8'h00, 8'h00);
    run_cmd(8'h21, 1'b0, 0, 16'h0000, 7'h02, 8'h00, 8'h00);
    run_cmd(8'h21, 1'b1, 0, 16'h0000, 7'h00, 8'h00, 8'h00);
    run_cmd(8'h03, 1'b1, 5, 16'h0040, 7'h00, 8'h00, 8'h00);
    // A reset in mid-run must clear a register that holds a set bit.
    CORE.wr(8'h57, 1'b0, 8'h80);
    nrst = 1'b0;
    repeat (3) @(negedge core_clk);
    nrst = 1'b1;
    repeat (4) @(negedge core_clk);
    chk(ready_irq, 1'b0);
    CORE.rd(8'h57, 1'b0, q);
    chk(q, 8'h00);
    complete_run();
  end
endmodule
`default_nettype wire
